// file: inc/pcbp_pkg.sv
// constants and carrier types for the parallel configuration byte port
package pcbp_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;
    localparam logic [11:0] ADDR_RESET    = 12'h000;
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          CLOCK_OUTPUT_HALF_NS = 50;
    localparam int          CLOCK_OUTPUT_HALF_CYC = (CLOCK_OUTPUT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  REV_RESET     = 2'h0;

    typedef struct packed {
        logic [7:0] data;
        logic       data_oe;
        logic       chain_enable_out_n;
    } pcbp_out_s;

    typedef struct packed {
        logic       revision_source_select;
        logic [1:0] revision_select;
    } pcbp_rev_s;
endpackage

// file: design/pcbp_top.sv
// byte-wide configuration data port with address counter, busy stall, cascade and revision select
//
// Functional notes
// - drive one byte at a time from memory at address counter
// - advance address counter on each valid rising config clock edge up to the last address
// - hold current byte while busy is high, resume after low
// - busy input delays next data transition until target ready
// - active-low reset input clears address counter before each configuration
// - data outputs driven while chip enable is low and the active-low reset input is high, up to the last byte
// - chain enable output drives next memory chip enable
// - config request pin bidirectional, drives and senses program input
// - slave mode: memory clock output may supply target clock
// - after last byte, chain enable low and data outputs released
// - revision source low uses pins, high uses internal bits
// - sample revision selection on rising edge of config request while chip enable is low
`timescale 1ns/100ps
module pcbp_top
    import pcbp_pkg::*;
#(
    parameter int          DEPTH    = 4096,
    parameter logic [11:0] LAST_ADDR = 12'hFFF,
    parameter logic [1:0]  INT_REV  = 2'h0
) (
    // clock and reset
    input  wire logic             CLOCK,
    input  wire logic             RESET_N,
    // configuration link
    input  wire logic             CONFIG_CLOCK,
    input  wire logic             BUSY,
    input  wire logic             OE_RESET_N,
    input  wire logic             CHIP_ENABLE_N,
    output logic                  CHAIN_ENABLE_OUT_N,
    output logic [DATA_W-1:0]     CONFIG_DATA_BYTE,
    output logic                  CONFIG_DATA_OE,
    output logic                  CLOCK_OUTPUT,
    // config request, open drain style
    input  wire logic             CONFIG_REQUEST_N_I,
    output logic                  CONFIG_REQUEST_N_O,
    output logic                  CONFIG_REQUEST_N_OE,
    input  wire logic             PROGRAM_REQUEST,
    // revision selection
    input  wire logic             REVISION_SOURCE_SELECT,
    input  wire logic [1:0]       REVISION_SELECT,
    output logic [1:0]            ACTIVE_REVISION,
    // memory load port, same clock
    input  wire logic             MEM_WR,
    input  wire logic [11:0]      MEM_WADDR,
    input  wire logic [DATA_W-1:0] MEM_WDATA
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // three stages; a change counts when stages two and three agree
    logic [2:0] config_clock_s_r, busy_s_r, oer_s_r, ce_s_r, cfr_s_r;
    logic [2:0] config_clock_s_nxt, busy_s_nxt, oer_s_nxt, ce_s_nxt, cfr_s_nxt;
    logic       config_clock_q_r, busy_q_r, oer_q_r, ce_q_r, cfr_q_r;
    logic       config_clock_q_nxt, busy_q_nxt, oer_q_nxt, ce_q_nxt, cfr_q_nxt;

    always_comb begin
        config_clock_s_nxt = {config_clock_s_r[1:0], CONFIG_CLOCK};
        busy_s_nxt = {busy_s_r[1:0], BUSY};
        oer_s_nxt  = {oer_s_r[1:0],  OE_RESET_N};
        ce_s_nxt   = {ce_s_r[1:0],   CHIP_ENABLE_N};
        cfr_s_nxt  = {cfr_s_r[1:0],  CONFIG_REQUEST_N_I};
        config_clock_q_nxt = (config_clock_s_r[2] == config_clock_s_r[1]) ? config_clock_s_r[2] : config_clock_q_r;
        busy_q_nxt = (busy_s_r[2] == busy_s_r[1]) ? busy_s_r[2] : busy_q_r;
        oer_q_nxt  = (oer_s_r[2]  == oer_s_r[1])  ? oer_s_r[2]  : oer_q_r;
        ce_q_nxt   = (ce_s_r[2]   == ce_s_r[1])   ? ce_s_r[2]   : ce_q_r;
        cfr_q_nxt  = (cfr_s_r[2]  == cfr_s_r[1])  ? cfr_s_r[2]  : cfr_q_r;
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            config_clock_s_r <= 3'h0;
            busy_s_r <= 3'h0;
            oer_s_r  <= 3'h0;
            ce_s_r   <= 3'h7;
            cfr_s_r  <= 3'h7;
            config_clock_q_r <= 1'b0;
            busy_q_r <= 1'b0;
            oer_q_r  <= 1'b0;
            ce_q_r   <= 1'b1;
            cfr_q_r  <= 1'b1;
        end else begin
            config_clock_s_r <= config_clock_s_nxt;
            busy_s_r <= busy_s_nxt;
            oer_s_r  <= oer_s_nxt;
            ce_s_r   <= ce_s_nxt;
            cfr_s_r  <= cfr_s_nxt;
            config_clock_q_r <= config_clock_q_nxt;
            busy_q_r <= busy_q_nxt;
            oer_q_r  <= oer_q_nxt;
            ce_q_r   <= ce_q_nxt;
            cfr_q_r  <= cfr_q_nxt;
        end
    end

    logic config_clock_rise;
    logic cfr_rise;
    assign config_clock_rise = config_clock_q_nxt && !config_clock_q_r;
    assign cfr_rise  = cfr_q_nxt && !cfr_q_r;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];

    always_ff @(posedge CLOCK) begin
        if (MEM_WR) begin
            mem_r[MEM_WADDR] <= MEM_WDATA;
        end
    end

    // ----------------------------------------
    // revision selection and address counter
    // ----------------------------------------
    pcbp_rev_s  rev_in;
    logic [1:0] rev_r, rev_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic        done_r, done_nxt;
    pcbp_out_s   out_r, out_nxt;
    logic        advance;

    assign rev_in.revision_source_select = REVISION_SOURCE_SELECT;
    assign rev_in.revision_select        = REVISION_SELECT;
    // busy stall and reset gate every counted edge
    assign advance = config_clock_rise && !busy_q_r && oer_q_r && !ce_q_r && !done_r;

    always_comb begin
        rev_nxt  = rev_r;
        addr_nxt = addr_r;
        done_nxt = done_r;
        if (cfr_rise && !ce_q_r) begin
            rev_nxt = rev_in.revision_source_select ? INT_REV : rev_in.revision_select;
        end
        if (!oer_q_r || ce_q_r) begin
            addr_nxt = ADDR_RESET;
            done_nxt = 1'b0;
        end else if (advance) begin
            if (addr_r == LAST_ADDR) begin
                done_nxt = 1'b1;
            end else begin
                addr_nxt = addr_r + 12'h001;
            end
        end
        out_nxt.data               = mem_r[addr_nxt];
        out_nxt.data_oe            = !ce_q_nxt && oer_q_nxt && !done_nxt;
        out_nxt.chain_enable_out_n = !done_nxt;
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rev_r  <= REV_RESET;
            addr_r <= ADDR_RESET;
            done_r <= 1'b0;
            out_r  <= '{data: 8'h00, data_oe: 1'b0, chain_enable_out_n: 1'b1};
        end else begin
            rev_r  <= rev_nxt;
            addr_r <= addr_nxt;
            done_r <= done_nxt;
            out_r  <= out_nxt;
        end
    end

    // ----------------------------------------
    // slave clock output
    // ----------------------------------------
    logic [7:0] div_r, div_nxt;
    logic       ck_r, ck_nxt;

    always_comb begin
        div_nxt = div_r + 8'h01;
        ck_nxt  = ck_r;
        if (div_r == 8'(CLOCK_OUTPUT_HALF_CYC - 1)) begin
            div_nxt = 8'h00;
            ck_nxt  = !ck_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_r <= 8'h00;
            ck_r  <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ck_r  <= ck_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign CONFIG_DATA_BYTE    = out_r.data;
    assign CONFIG_DATA_OE      = out_r.data_oe;
    assign CHAIN_ENABLE_OUT_N  = out_r.chain_enable_out_n;
    assign CLOCK_OUTPUT        = ck_r;
    assign ACTIVE_REVISION     = rev_r;
    // pulls low only; pin is sensed back through the synchroniser
    assign CONFIG_REQUEST_N_O  = 1'b0;
    assign CONFIG_REQUEST_N_OE = PROGRAM_REQUEST;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // a deselect clears the counter even under busy, so it is left out here
    stall_hold_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        busy_q_r && oer_q_r && !ce_q_r |=> addr_r == $past(addr_r))
        else $error("address moved while busy");
    count_step_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        advance && addr_r != LAST_ADDR |=> addr_r == $past(addr_r) + 12'h001)
        else $error("address did not step");
    reset_clear_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !oer_q_r |=> addr_r == ADDR_RESET && !done_r)
        else $error("counter not cleared");
    // output enable is registered from the same flags, so compare in the same cycle
    ce_release_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        ce_q_r |-> !CONFIG_DATA_OE)
        else $error("driving while deselected");
    ce_drive_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !ce_q_r && oer_q_r && !done_r ##1 !ce_q_r && oer_q_r && !done_r |-> CONFIG_DATA_OE)
        else $error("not driving while selected");
    chain_hand_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        done_r |-> !CHAIN_ENABLE_OUT_N && !CONFIG_DATA_OE)
        else $error("cascade hand-off wrong");
    chain_idle_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !done_r |-> CHAIN_ENABLE_OUT_N)
        else $error("chain enable early");
    rev_sample_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !cfr_rise |=> rev_r == $past(rev_r))
        else $error("revision changed without request");
    rev_src_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        cfr_rise && !ce_q_r && REVISION_SOURCE_SELECT |=> rev_r == INT_REV)
        else $error("internal revision not chosen");
endmodule

// file: bench/pcbp_target_model.sv
// target-side model: config clock source, busy and byte capture
`timescale 1ns/100ps
module pcbp_target_model (
    // bench control
    input  wire logic        stall,
    input  wire logic [15:0] want,
    // link
    input  wire logic [7:0]  data,
    output logic             cfg_clk,
    output logic             busy,
    // capture
    output logic [7:0]       cap,
    output logic [15:0]      n_cap
);
    // target's own select and write strobes held low so it accepts bytes
    logic target_select_n;
    logic target_write_n;

    assign target_select_n = 1'b0;
    assign target_write_n  = 1'b0;
    assign busy = stall;
    // clock stands low between frames; byte taken on the rise, before the memory steps
    initial begin
        cfg_clk = 1'b0;
        cap = 8'h00;
        n_cap = 16'h0000;
        forever begin
            wait (n_cap < want);
            #62.5 cfg_clk = 1'b1;
            if (!target_select_n && !target_write_n) begin
                cap = data;
            end
            n_cap = n_cap + 16'h0001;
            #62.5 cfg_clk = 1'b0;
        end
    end
endmodule

// file: bench/tb.sv
// self-checking bench for the configuration byte port
`timescale 1ns/100ps
module tb;
    import pcbp_pkg::*;
    logic        clk, rst_n, oe_rst_n, ce_n, stall, prog_lo, preq, rsrc, mwr;
    logic        ccl, busy, chain_n, doe, ckout, req_o, req_oe, req_w;
    logic [1:0]  rsel, arev;
    logic [7:0]  dbyte, bus, cap, mdata;
    logic [11:0] maddr;
    logic [15:0] want, n_cap;
    int          n_fail, n_checks;

    // released bus shows the inverse of the last byte; request pin has a pull-up
    assign bus = doe ? dbyte : ~dbyte;
    assign req_w = !(req_oe && !req_o) && !prog_lo;

    pcbp_top #(.LAST_ADDR(12'h007), .INT_REV(2'h3)) u_dut (
        .CLOCK(clk), .RESET_N(rst_n), .CONFIG_CLOCK(ccl), .BUSY(busy), .OE_RESET_N(oe_rst_n),
        .CHIP_ENABLE_N(ce_n), .CHAIN_ENABLE_OUT_N(chain_n), .CONFIG_DATA_BYTE(dbyte),
        .CONFIG_DATA_OE(doe), .CLOCK_OUTPUT(ckout), .CONFIG_REQUEST_N_I(req_w),
        .CONFIG_REQUEST_N_O(req_o), .CONFIG_REQUEST_N_OE(req_oe), .PROGRAM_REQUEST(preq),
        .REVISION_SOURCE_SELECT(rsrc), .REVISION_SELECT(rsel), .ACTIVE_REVISION(arev),
        .MEM_WR(mwr), .MEM_WADDR(maddr), .MEM_WDATA(mdata));
    pcbp_target_model u_tgt (.stall(stall), .want(want), .data(bus), .cfg_clk(ccl), .busy(busy),
        .cap(cap), .n_cap(n_cap));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait for n config clock periods from the model
    task automatic edges(input int n);
        want = n_cap + 16'(n);
        for (int i = 0; i < 40 * n && n_cap < want; i++) @(negedge clk);
        if (n_cap < want) begin
            n_fail++;
            $display("Error t=%0t timeout got=%h exp=%h", $time, n_cap, want);
            summarize();
        end
        // the memory answers a few cycles after the pin edge; let it settle
        cyc(8);
    endtask

    task automatic pull();
        prog_lo = 1'b1;
        cyc(10);
        prog_lo = 1'b0;
        cyc(10);
    endtask

    task automatic t_stream_busy();
        edges(1);
        chk(cap, 8'hA0);
        chk({7'h00, doe}, 8'h01);
        stall = 1'b1;
        edges(2);
        chk(cap, 8'hA1);
        chk(dbyte, 8'hA1);
        stall = 1'b0;
        edges(1);
        chk(cap, 8'hA1);
        chk(dbyte, 8'hA2);
        $display("stream and busy done");
    endtask

    task automatic t_ce_init();
        // chip enable toggles like a completion line, never tied low
        ce_n = 1'b1;
        edges(1);
        chk({7'h00, doe}, 8'h00);
        ce_n = 1'b0;
        edges(1);
        chk(cap, 8'hA0);
        oe_rst_n = 1'b0;
        stall = 1'b1;
        edges(1);
        chk({7'h00, doe}, 8'h00);
        oe_rst_n = 1'b1;
        stall = 1'b0;
        edges(1);
        chk(cap, 8'hA0);
        $display("select and init done");
    endtask

    task automatic t_rev();
        logic v;
        rsel = 2'h2;
        pull();
        chk({6'h00, arev}, 8'h02);
        rsrc = 1'b1;
        pull();
        chk({6'h00, arev}, 8'h03);
        preq = 1'b1;
        cyc(1);
        chk({7'h00, req_oe}, 8'h01);
        preq = 1'b0;
        cyc(10);
        v = ckout;
        cyc(CLOCK_OUTPUT_HALF_CYC);
        chk({7'h00, ckout}, {7'h00, ~v});
        $display("revision done");
    endtask

    task automatic t_last();
        edges(6);
        chk(cap, 8'hA6);
        edges(1);
        chk(cap, 8'hA7);
        chk({7'h00, chain_n}, 8'h00);
        chk({7'h00, doe}, 8'h00);
        $display("cascade done");
    endtask

    initial begin
        {rst_n, stall, prog_lo, preq, rsrc, mwr, ce_n} = 7'h00;
        oe_rst_n = 1'b1;
        {rsel, maddr, mdata, want} = 38'h0;
        n_fail = 0;
        n_checks = 0;
        cyc(2);
        rst_n = 1'b1;
        cyc(8);
        chk({7'h00, chain_n}, 8'h01);
        for (int a = 0; a < 8; a++) begin
            mwr = 1'b1;
            maddr = 12'(a);
            mdata = 8'hA0 + 8'(a);
            cyc(1);
        end
        mwr = 1'b0;
        cyc(10);
        t_stream_busy();
        t_ce_init();
        t_rev();
        t_last();
        summarize();
    end
endmodule
